// ### core/smc_control.sv
// SMBus control register with prescaler, glitch filters and overrides
`timescale 1ns/10ps
`default_nettype none

module smc_control
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Control register port
  input wire logic ctl_wr_en,
  input wire logic [31:0] ctl_wr_data,
  output logic [31:0] ctl_rd_data,
  // Boot strap
  input wire logic master_slow_select,
  // Master bus pins
  input wire logic master_bus_clock,
  output logic master_bus_clock_low,
  output logic master_bus_clock_en,
  input wire logic master_bus_data,
  output logic master_bus_data_low,
  output logic master_bus_data_en,
  // Slave bus pins
  input wire logic slave_bus_clock,
  output logic slave_bus_clock_low,
  output logic slave_bus_clock_en,
  input wire logic slave_bus_data,
  output logic slave_bus_data_low,
  output logic slave_bus_data_en,
  // Master and slave engine side
  input wire logic master_busy,
  input wire logic master_data_pull,
  input wire logic slave_busy,
  input wire logic slave_clock_hold,
  input wire logic slave_data_pull,
  input wire logic arb_lost,
  input wire logic sum_bad,
  output logic arb_abort,
  output logic sum_error,
  output logic master_phase,
  output logic master_clock_seen,
  output logic master_data_seen,
  output logic slave_clock_seen,
  output logic slave_data_seen
);

  typedef struct packed {
    logic [15:0] prescale;
    logic ign_arb;
    logic ign_sum;
    logic [1:0] smode;
    logic [1:0] mmode;
    logic [15:0] act_prescale;
    logic [1:0] act_smode;
    logic [1:0] act_mmode;
    logic strap_s1;
    logic strap_s2;
    logic [LANES-1:0] pin_s1;
    logic [LANES-1:0] pin_s2;
    logic [31:0] rd_data;
    logic mclk_en;
    logic mdat_en;
    logic sclk_en;
    logic sdat_en;
    logic arb_abort;
    logic sum_error;
    logic phase;
    logic [LANES-1:0] seen;
  } smc_state_t;

  smc_state_t st_r;
  smc_state_t st_nxt;

  smc_lane_if lane [LANES] ();
  smc_pre_if pre ();

  logic [LANES-1:0] clean;

  ////////////////////////////////////////////////////////////////////////
  // Filter delay decode, shared by master and slave lanes

  function automatic logic [FILT_W-1:0] filt_cycles(input logic [1:0] mode);
    logic [FILT_W-1:0] cyc;
    case (mode)
      MODE_NORMAL: cyc = FILT_NORMAL_CYC;
      MODE_FAST: cyc = FILT_FAST_CYC;
      MODE_OFF: cyc = FILT_OFF_CYC;
      default: cyc = FILT_NORMAL_CYC; // Reserved never gets stored
    endcase
    return cyc;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Filters on the four bus lines, fed from the synchronisers

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++)
    begin : g_lane
      assign lane[gi].raw = st_r.pin_s2[gi];
      // slave lanes use the slave mode
      // master lanes use the master mode
      assign lane[gi].delay = (gi < LANE_SCLK) ?
        filt_cycles(st_r.act_mmode) : filt_cycles(st_r.act_smode);
      assign clean[gi] = lane[gi].clean;
      smc_glitch_filter u_filt (
        .clk (clk),
        .rst (rst),
        .lane (lane[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Prescaler runs from the applied setting only

  assign pre.period = st_r.act_prescale;

  smc_prescaler u_pre (
    .clk (clk),
    .rst (rst),
    .pre (pre)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    st_nxt = st_r;

    // Pins and strap cross in through two flops
    st_nxt.pin_s1 = {slave_bus_data, slave_bus_clock,
                     master_bus_data, master_bus_clock};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.strap_s1 = master_slow_select;
    st_nxt.strap_s2 = st_r.strap_s1;

    // Register write; a reserved mode code leaves the field alone
    if (ctl_wr_en)
    begin
      st_nxt.prescale = ctl_wr_data[PRESCALE_LSB +: PRESCALE_W];
      st_nxt.ign_arb = ctl_wr_data[IGN_ARB_BIT];
      st_nxt.ign_sum = ctl_wr_data[IGN_SUM_BIT];
      if (ctl_wr_data[SMODE_LSB +: MODE_W] != MODE_RSVD)
      begin
        st_nxt.smode = ctl_wr_data[SMODE_LSB +: MODE_W];
      end
      if (ctl_wr_data[MMODE_LSB +: MODE_W] != MODE_RSVD)
      begin
        st_nxt.mmode = ctl_wr_data[MMODE_LSB +: MODE_W];
      end
    end

    if (!master_busy)
    begin
      st_nxt.act_prescale = st_r.prescale;
      st_nxt.act_mmode = st_r.mmode;
    end
    if (!slave_busy)
    begin
      st_nxt.act_smode = st_r.smode;
    end

    // pull clock low only in the low phase
    st_nxt.mclk_en = master_busy & pre.run & ~pre.level;
    st_nxt.mdat_en = master_busy & master_data_pull;
    st_nxt.sclk_en = slave_busy & slave_clock_hold;
    st_nxt.sdat_en = slave_busy & slave_data_pull;
    st_nxt.phase = pre.level;

    st_nxt.arb_abort = arb_lost & ~st_r.ign_arb;
    st_nxt.sum_error = sum_bad & ~st_r.ign_sum;

    st_nxt.seen = clean;

    // Synchronous reset; strap keeps shifting so it is caught here
    if (rst)
    begin
      st_nxt.prescale = st_r.strap_s2 ? PRESCALE_SLOW : PRESCALE_FAST;
      st_nxt.act_prescale = st_nxt.prescale;
      st_nxt.ign_arb = IGN_RST;
      st_nxt.ign_sum = IGN_RST;
      st_nxt.smode = MODE_RST;
      st_nxt.mmode = MODE_RST;
      st_nxt.act_smode = MODE_RST;
      st_nxt.act_mmode = MODE_RST;
      st_nxt.mclk_en = 1'b0;
      st_nxt.mdat_en = 1'b0;
      st_nxt.sclk_en = 1'b0;
      st_nxt.sdat_en = 1'b0;
      st_nxt.arb_abort = 1'b0;
      st_nxt.sum_error = 1'b0;
      st_nxt.phase = 1'b1;
      st_nxt.seen = '1;
    end

    // Read view always mirrors the stored fields; unused bits are zero
    st_nxt.rd_data = '0;
    st_nxt.rd_data[PRESCALE_LSB +: PRESCALE_W] = st_nxt.prescale;
    st_nxt.rd_data[IGN_ARB_BIT] = st_nxt.ign_arb;
    st_nxt.rd_data[IGN_SUM_BIT] = st_nxt.ign_sum;
    st_nxt.rd_data[SMODE_LSB +: MODE_W] = st_nxt.smode;
    st_nxt.rd_data[MMODE_LSB +: MODE_W] = st_nxt.mmode;
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; open-drain lines only ever pull low

  assign ctl_rd_data = st_r.rd_data;
  assign master_bus_clock_low = 1'b0;
  assign master_bus_clock_en = st_r.mclk_en;
  assign master_bus_data_low = 1'b0;
  assign master_bus_data_en = st_r.mdat_en;
  assign slave_bus_clock_low = 1'b0;
  assign slave_bus_clock_en = st_r.sclk_en;
  assign slave_bus_data_low = 1'b0;
  assign slave_bus_data_en = st_r.sdat_en;
  assign arb_abort = st_r.arb_abort;
  assign sum_error = st_r.sum_error;
  assign master_phase = st_r.phase;
  assign master_clock_seen = st_r.seen[LANE_MCLK];
  assign master_data_seen = st_r.seen[LANE_MDAT];
  assign slave_clock_seen = st_r.seen[LANE_SCLK];
  assign slave_data_seen = st_r.seen[LANE_SDAT];

endmodule

`default_nettype wire

// ### core/smc_pkg.sv
// Constants and field layout for the SMBus control block
package smc_pkg;

  // Core clock and prescaler base
  localparam int CLK_MHZ = 125;
  localparam int PRESCALE_BASE_NS = 32;
  // Core cycles per half prescaler unit (the low phase is half the period)
  localparam int HALF_CYC_PER_UNIT = (PRESCALE_BASE_NS * CLK_MHZ) / 2000;

  // Glitch filter delays; "about" figures, rounded down to whole cycles
  localparam int FILT_NORMAL_NS = 1000;
  localparam int FILT_FAST_NS = 100;
  localparam int FILT_W = 8;
  localparam logic [FILT_W-1:0] FILT_NORMAL_CYC =
    FILT_W'((FILT_NORMAL_NS * CLK_MHZ) / 1000);
  localparam logic [FILT_W-1:0] FILT_FAST_CYC =
    FILT_W'((FILT_FAST_NS * CLK_MHZ) / 1000);
  localparam logic [FILT_W-1:0] FILT_OFF_CYC = 8'h00;

  // Control register field positions
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 16;
  localparam int IGN_ARB_BIT = 16;
  localparam int IGN_SUM_BIT = 17;
  localparam int SMODE_LSB = 18;
  localparam int MMODE_LSB = 20;
  localparam int MODE_W = 2;

  // Values after reset
  localparam logic [15:0] PRESCALE_SLOW = 16'h0139;
  localparam logic [15:0] PRESCALE_FAST = 16'h0053;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic IGN_RST = 1'b0;

  // Filter mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FAST = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Pin lane indices
  localparam int LANE_MCLK = 0;
  localparam int LANE_MDAT = 1;
  localparam int LANE_SCLK = 2;
  localparam int LANE_SDAT = 3;
  localparam int LANES = 4;

endpackage

// ### core/smc_if.sv
// Carriers between the control top and its filter and prescaler
`timescale 1ns/10ps
`default_nettype none

interface smc_lane_if;
  import smc_pkg::*;
  logic raw;
  logic [FILT_W-1:0] delay;
  logic clean;
  modport ctl (output raw, output delay, input clean);
  modport filt (input raw, input delay, output clean);
endinterface

interface smc_pre_if;
  logic [15:0] period;
  logic run;
  logic level;
  modport ctl (output period, input run, input level);
  modport gen (input period, output run, output level);
endinterface

`default_nettype wire

// ### core/smc_glitch_filter.sv
// Glitch filter: output follows the input once it has held steady
`timescale 1ns/10ps
`default_nettype none

module smc_glitch_filter
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  smc_lane_if.filt lane
);

  typedef struct packed {
    logic clean;
    logic [FILT_W-1:0] cnt;
  } smc_filt_t;

  smc_filt_t st_r;
  smc_filt_t st_nxt;

  // Count steady cycles; any bounce back restarts the wait
  always_comb
  begin
    st_nxt = st_r;
    if (lane.delay == '0)
    begin
      st_nxt.clean = lane.raw;
      st_nxt.cnt = '0;
    end
    else if (lane.raw == st_r.clean)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt >= lane.delay - 8'h01)
    begin
      st_nxt.clean = lane.raw;
      st_nxt.cnt = '0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    // Idle bus floats high
    if (rst)
    begin
      st_nxt.clean = 1'b1;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  assign lane.clean = st_r.clean;

endmodule

`default_nettype wire

// ### core/smc_prescaler.sv
// Master bus clock prescaler: square wave, period = setting x 32 ns
`timescale 1ns/10ps
`default_nettype none

module smc_prescaler
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  smc_pre_if.gen pre
);

  typedef struct packed {
    logic run;
    logic level;
    logic [16:0] cnt;
  } smc_pre_t;

  smc_pre_t st_r;
  smc_pre_t st_nxt;
  logic [16:0] half_cyc;

  // Each phase lasts half the period, which sets the minimum low time
  assign half_cyc = 17'(pre.period) * 17'(HALF_CYC_PER_UNIT);

  always_comb
  begin
    st_nxt = st_r;
    if (pre.period <= 16'h0001)
    begin
      st_nxt.run = 1'b0;
      st_nxt.level = 1'b1;
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt >= half_cyc - 17'h00001)
    begin
      st_nxt.run = 1'b1;
      st_nxt.level = ~st_r.level;
      st_nxt.cnt = '0;
    end
    else
    begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = st_r.cnt + 17'h00001;
    end
    if (rst)
    begin
      st_nxt.run = 1'b0;
      st_nxt.level = 1'b1;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  assign pre.run = st_r.run;
  assign pre.level = st_r.level;

endmodule

`default_nettype wire

// ### bench/smc_bus_peer.sv
// Far-side bus devices: pull-ups plus external pull-downs on four lines
`timescale 1ns/10ps
`default_nettype none

module smc_bus_peer
  import smc_pkg::*;
(
  input wire logic [LANES-1:0] dut_pull,
  input wire logic [LANES-1:0] peer_pull,
  output logic [LANES-1:0] line
);
  // Open drain: any puller wins, else the pull-up lifts the line
  always_comb
  begin
    line = ~(dut_pull | peer_pull);
  end
endmodule

`default_nettype wire

// ### bench/smc_control_sva.sv
// Concurrent checks on the control block's ports
`timescale 1ns/10ps
`default_nettype none

module smc_control_sva
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctl_wr_en,
  input wire logic [31:0] ctl_wr_data,
  input wire logic [31:0] ctl_rd_data,
  input wire logic master_bus_clock,
  input wire logic slave_bus_data,
  input wire logic master_busy,
  input wire logic arb_lost,
  input wire logic sum_bad,
  input wire logic arb_abort,
  input wire logic sum_error,
  input wire logic master_phase,
  input wire logic master_bus_clock_en,
  input wire logic master_clock_seen,
  input wire logic slave_data_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [17:0] lo_cnt_r;
  logic wr_seen_r;

  //////////////////////////////////////////////////////////////////////
  // Low-phase length; a write or busy spoils the period being timed
  always_ff @(posedge clk)
  begin
    if (rst || master_phase)
      lo_cnt_r <= 18'h00000;
    else
      lo_cnt_r <= lo_cnt_r + 18'h00001;
    if (rst || ctl_wr_en || master_busy)
      wr_seen_r <= 1'b1;
    else if (master_phase && lo_cnt_r != 18'h00000)
      wr_seen_r <= 1'b0;
  end

  sequence s_stopped_idle;
    (!master_busy && ctl_rd_data[15:0] <= 16'h0001)[*4];
  endsequence

  //////////////////////////////////////////////////////////////////////
  // override, readback, reserved mode, prescaler and filter checks
  a_arb_gate:
    assert property (arb_abort == $past(arb_lost & ~ctl_rd_data[16]))
    else $error("abort does not follow loss and override bit");
  a_sum_gate:
    assert property (sum_error == $past(sum_bad & ~ctl_rd_data[17]))
    else $error("checksum error does not follow its override bit");
  a_wr_readback:
    assert property (ctl_wr_en && ctl_wr_data[21:20] != MODE_RSVD &&
      ctl_wr_data[19:18] != MODE_RSVD |=>
      ctl_rd_data == {10'h000, $past(ctl_wr_data[21:0])})
    else $error("written word not read back");
  a_mmode_rsvd:
    assert property (ctl_wr_en && ctl_wr_data[21:20] == MODE_RSVD |=>
      $stable(ctl_rd_data[21:20]))
    else $error("reserved master mode was taken");
  a_smode_rsvd:
    assert property (ctl_wr_en && ctl_wr_data[19:18] == MODE_RSVD |=>
      $stable(ctl_rd_data[19:18]))
    else $error("reserved slave mode was taken");
  a_pre_stop:
    assert property (s_stopped_idle |-> master_phase)
    else $error("prescaler runs with setting zero or one");
  a_clk_pull:
    assert property (master_bus_clock_en ==
      ($past(master_busy) && !master_phase))
    else $error("clock pull not tied to busy and low phase");
  a_low_half:
    assert property ($rose(master_phase) && !wr_seen_r |->
      lo_cnt_r == {1'b0, ctl_rd_data[15:0], 1'b0})
    else $error("low phase is not half the prescaler period");
  a_mclk_filter:
    assert property ($changed(master_clock_seen) |->
      $past(master_bus_clock, 4) == master_clock_seen)
    else $error("master clock seen moved without a held pin");
  a_sdat_filter:
    assert property ($changed(slave_data_seen) |->
      $past(slave_bus_data, 4) == slave_data_seen)
    else $error("slave data seen moved without a held pin");
endmodule

bind smc_control smc_control_sva chk (.*);

`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the SMBus control block
`timescale 1ns/10ps
`default_nettype none

module testbench
  import smc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ctl_wr_en = 1'b0;
  logic [31:0] ctl_wr_data = 32'h00000000;
  logic [31:0] ctl_rd_data;
  logic master_slow_select = 1'b1;
  logic master_busy = 1'b0;
  logic master_data_pull = 1'b0;
  logic slave_busy = 1'b0;
  logic slave_clock_hold = 1'b0;
  logic slave_data_pull = 1'b0;
  logic arb_lost = 1'b0;
  logic sum_bad = 1'b0;
  logic arb_abort, sum_error, master_phase;
  logic [LANES-1:0] peer_pull = 4'h0;
  wire logic [LANES-1:0] dut_pull, line, seen;
  int mismatches = 0;
  int check_count = 0;
  int dly [3] = '{int'(FILT_NORMAL_CYC) + 3, int'(FILT_FAST_CYC) + 3, 4};

  //////////////////////////////////////////////////////////////////////
  // Core clock, 8 ns
  initial
  begin
    forever #4 clk = ~clk;
  end

  // Device and the far-side bus devices
  smc_control dut (
    .clk, .rst, .ctl_wr_en, .ctl_wr_data, .ctl_rd_data, .master_slow_select,
    .master_bus_clock(line[LANE_MCLK]), .master_bus_clock_low(),
    .master_bus_clock_en(dut_pull[LANE_MCLK]),
    .master_bus_data(line[LANE_MDAT]), .master_bus_data_low(),
    .master_bus_data_en(dut_pull[LANE_MDAT]),
    .slave_bus_clock(line[LANE_SCLK]), .slave_bus_clock_low(),
    .slave_bus_clock_en(dut_pull[LANE_SCLK]),
    .slave_bus_data(line[LANE_SDAT]), .slave_bus_data_low(),
    .slave_bus_data_en(dut_pull[LANE_SDAT]),
    .master_busy, .master_data_pull, .slave_busy, .slave_clock_hold,
    .slave_data_pull, .arb_lost, .sum_bad, .arb_abort, .sum_error,
    .master_phase, .master_clock_seen(seen[LANE_MCLK]),
    .master_data_seen(seen[LANE_MDAT]), .slave_clock_seen(seen[LANE_SCLK]),
    .slave_data_seen(seen[LANE_SDAT])
  );
  smc_bus_peer peer (.dut_pull, .peer_pull, .line);

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Register write: one-cycle strobe, launched off the falling edge
  task automatic wr(input logic [31:0] d);
    @(negedge clk);
    ctl_wr_en = 1'b1;
    ctl_wr_data = d;
    @(negedge clk);
    ctl_wr_en = 1'b0;
  endtask

  // Eight cycles of reset with the strap held steady
  task automatic do_reset(input logic s);
    @(negedge clk);
    rst = 1'b1;
    master_slow_select = s;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask

  function automatic logic probe(input int sel);
    return (sel == LANES) ? master_phase : seen[sel];
  endfunction

  // Bounded wait; a hang ends the run
  task automatic wait_for(input int sel, input logic v, output int n);
    n = 0;
    while (probe(sel) !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      $display("[FAIL] wait expected %h seen %h", v, probe(sel));
      close_out();
    end
  endtask

  // Times one whole high and one whole low phase
  task automatic measure(input int p);
    int a, b;
    wait_for(LANES, 1'b0, a);
    wait_for(LANES, 1'b1, a);
    wait_for(LANES, 1'b0, a);
    wait_for(LANES, 1'b1, b);
    chk("phase high", 32'(2 * p), 32'(a));
    chk("phase low", 32'(2 * p), 32'(b));
  endtask

  task automatic filt(input int lane, input int exp);
    int n;
    peer_pull[lane] = 1'b1;
    wait_for(lane, 1'b0, n);
    chk("filter fall", 32'(exp), 32'(n));
    peer_pull[lane] = 1'b0;
    wait_for(lane, 1'b1, n);
    chk("filter rise", 32'(exp), 32'(n));
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int m, bad;
    do_reset(1'b1);
    chk("slow default", 32'h00000139, ctl_rd_data);
    do_reset(1'b0);
    chk("fast default", 32'h00000053, ctl_rd_data);
    wr(32'h00150200);
    chk("readback", 32'h00150200, ctl_rd_data);
    wr(32'h00fd0000);
    chk("rsvd modes", 32'h00150000, ctl_rd_data);
    wr(32'h00000004);
    measure(4);
    // zero and one stop the clock
    for (m = 0; m < 2; m++)
    begin
      wr(32'(m));
      repeat (4) @(negedge clk);
      bad = 0;
      repeat (100)
      begin
        @(negedge clk);
        bad += int'(master_phase !== 1'b1);
      end
      chk("stopped", 32'h0, 32'(bad));
    end
    // new setting waits for the transfer to end
    wr(32'h00000004);
    // Idle engine must copy the new period before busy freezes it
    repeat (2) @(negedge clk);
    {master_busy, master_data_pull} = 2'h3;
    {slave_busy, slave_clock_hold, slave_data_pull} = 3'h7;
    wr(32'h00000008);
    measure(4);
    chk("engine pulls", 32'h7, {29'h0, dut_pull[3:1]});
    {master_busy, master_data_pull} = 2'h0;
    {slave_busy, slave_clock_hold, slave_data_pull} = 3'h0;
    measure(8);
    chk("released", 32'h0, {28'h0, dut_pull});
    // override bits gate the error pulses
    for (m = 0; m < 2; m++)
    begin
      wr({14'h0000, m[0], m[0], 16'h0004});
      {arb_lost, sum_bad} = 2'h3;
      @(negedge clk);
      {arb_lost, sum_bad} = 2'h0;
      chk("arb abort", 32'(!m[0]), {31'h0, arb_abort});
      chk("sum error", 32'(!m[0]), {31'h0, sum_error});
    end
    // filter delay in every usable mode
    for (m = 0; m < 3; m++)
    begin
      wr({10'h000, 2'(m), 2'(m), 18'h00004});
      repeat (4) @(negedge clk);
      filt(LANE_MCLK, dly[m]);
      filt(LANE_MDAT, dly[m]);
      filt(LANE_SCLK, dly[m]);
      filt(LANE_SDAT, dly[m]);
    end
    close_out();
  end
endmodule

`default_nettype wire
